// ==== rtl/gp_pin_pkg.sv ====
// Shared types and constants of the general-purpose pin block.
// Assumes one management clock and that register access arrives as single-cycle strobes.
package gp_pin_pkg;

   // Management register numbers within a page.
   localparam logic [4:0]  PAGE_SEL_REG  = 5'h1f;
   localparam logic [4:0]  CTRL_TWO_REG  = 5'h0e;
   localparam logic [4:0]  IN_LEVEL_REG  = 5'h0f;
   localparam logic [4:0]  OUT_VALUE_REG = 5'h10;
   localparam logic [4:0]  OUT_EN_REG    = 5'h11;

   // Page codes written into the page select register.
   localparam logic [15:0] PAGE_GENERAL  = 16'h0010;
   localparam logic [15:0] PAGE_MAIN     = 16'h0000;

   // Implemented pin bits: 13..8, 5..4 and 1..0.
   localparam logic [15:0] PIN_MASK      = 16'h3f33;

   // Fields of the second pin control register.
   localparam int          HI_PAIR_LSB   = 14;
   localparam int          HOLD_DIR_BIT  = 13;
   localparam int          HOLD_DATA_BIT = 12;
   localparam int          HOLD_READ_BIT = 11;
   localparam int          TWI_REL_BIT   = 10;
   localparam int          LED_REL_BIT   = 9;
   localparam int          PPS_EN_BIT    = 8;
   localparam int          PIN11_LSB     = 6;
   localparam int          PIN10_LSB     = 4;
   localparam int          PIN9_LSB      = 2;
   localparam int          PIN8_LSB      = 0;
   localparam logic [1:0]  SEL_GENERAL   = 2'h3;
   localparam logic [1:0]  SEL_DEDICATED = 2'h0;
   localparam logic [15:0] CTRL_TWO_RST  = 16'h2600;
   localparam logic [15:0] CTRL_TWO_WMSK = 16'hf7ff;

   // Pin positions with a dedicated function.
   localparam int          SDA_PIN       = 8;
   localparam int          LINK_PIN      = 9;
   localparam int          SCL0_PIN      = 4;
   localparam int          SCL1_PIN      = 5;

   // Synchroniser width: sixteen pin positions plus the hold pin on top.
   localparam int          SYNC_W        = 17;
   localparam int          HOLD_SYNC_BIT = 16;

   // One management request, valid for the cycle its strobe is high.
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [4:0]  addr;
      logic [15:0] wdata;
   } mgmt_req_t;

   // Values that the dedicated pin functions want to put out.
   typedef struct packed {
      logic       sda;
      logic [1:0] scl;
      logic       link_loss;
      logic [3:0] led;
      logic [2:0] pulse_per_second_out;
   } func_drive_t;

   // Everything driven toward the pads.
   typedef struct packed {
      logic [15:0] gpio_out;
      logic [15:0] gpio_oe;
      logic        hold_out;
      logic        hold_oe;
      logic [3:0]  led_out;
      logic [3:0]  led_oe;
      logic [2:0]  pps_out;
      logic [2:0]  pps_oe;
   } pad_drive_t;

   // Whole state of the control module.
   typedef struct packed {
      logic [15:0] page;
      logic [15:0] ctrl_two;
      logic [15:0] out_value;
      logic [15:0] out_en;
      logic [15:0] rd_data;
      logic        rd_valid;
      pad_drive_t  pads;
   } ctrl_state_t;

   // Whole state of the synchroniser.
   typedef struct packed {
      logic [SYNC_W-1:0] s1;
      logic [SYNC_W-1:0] s2;
      logic [SYNC_W-1:0] s3;
      logic [SYNC_W-1:0] level;
   } sync_state_t;

endpackage

// ==== rtl/phy_gpio_pin_control.sv ====
// General-purpose pin control of a dual-port PHY: function select, hold pin, release modes.
// Assumes paged management accesses arrive as one-cycle strobes on the management clock.

// Operation
// - Pins 13..10 go general-purpose only at code 11.
// - Bit 13 low makes hold pin output.
// - Output hold pin drives bit 12 level.
// - Bit 11 reads back hold pin level.
// - Bit 10 releases two-wire highs to high-impedance.
// - Bit 9 releases LED highs to high-impedance.
// - Bit 8 gates pulse-per-second outputs; keep zero.
// - Pins 9,8 dedicated at 00, general at 11.
// - Input register returns present implemented pin levels.
// - Output register levels drive general-purpose pins.
// - Output register resets zero; reserved bits read-only.
// - Output-enable register picks input or driven.
module phy_gpio_pin_control (
   input  wire logic                      clk,
   input  wire logic                      resetn,
   input  wire gp_pin_pkg::mgmt_req_t     req,
   output logic      [15:0]               rd_data,
   output logic                           rd_valid,
   input  wire logic [15:0]               gpio_in,
   input  wire logic                      low_power_hold_pin_in,
   input  wire logic [3:0]                low_pins_general,
   input  wire gp_pin_pkg::func_drive_t   func,
   output gp_pin_pkg::pad_drive_t         pads
);

   gp_pin_pkg::ctrl_state_t st;       // Registered state.
   gp_pin_pkg::ctrl_state_t next_st;  // Next state.
   logic [gp_pin_pkg::SYNC_W-1:0] synced;  // Pad levels in the clock domain.
   logic [15:0] owned;                // Pins under general-purpose control.
   logic        page_ok;              // General page is selected.

   // Which pins software controls, from the select fields and the low-pin selects.
   function automatic logic [15:0] general_pins(input logic [15:0] c, input logic [3:0] lo);
      logic [15:0] m;
      m      = '0;
      m[13]  = c[gp_pin_pkg::HI_PAIR_LSB +: 2] == gp_pin_pkg::SEL_GENERAL;
      m[12]  = m[13];
      m[11]  = c[gp_pin_pkg::PIN11_LSB +: 2] == gp_pin_pkg::SEL_GENERAL;
      m[10]  = c[gp_pin_pkg::PIN10_LSB +: 2] == gp_pin_pkg::SEL_GENERAL;
      m[9]   = c[gp_pin_pkg::PIN9_LSB +: 2] == gp_pin_pkg::SEL_GENERAL;
      m[8]   = c[gp_pin_pkg::PIN8_LSB +: 2] == gp_pin_pkg::SEL_GENERAL;
      m[5:4] = lo[3:2];
      m[1:0] = lo[1:0];
      return m;
   endfunction

   // Open-drain style enable: a released high is not driven.
   function automatic logic drive_en(input logic val, input logic release_high);
      return !val || !release_high;
   endfunction

   // Pad levels enter through the synchroniser.
   pin_level_sync u_sync (
      .clk    (clk),
      .resetn (resetn),
      .raw    ({low_power_hold_pin_in, gpio_in}),
      .level  (synced)
   );

   assign owned   = general_pins(st.ctrl_two, low_pins_general);
   assign page_ok = st.page == gp_pin_pkg::PAGE_GENERAL;

   // Register access and pad drive computation.
   always_comb begin
      next_st          = st;
      next_st.rd_valid = req.rd;
      next_st.rd_data  = '0;
      // Writes: the page register is always reachable, the rest only on the general page.
      if (req.wr) begin
         if (req.addr == gp_pin_pkg::PAGE_SEL_REG) begin
            next_st.page = req.wdata;
         end else if (page_ok) begin
            case (req.addr)
               gp_pin_pkg::CTRL_TWO_REG: begin
                  next_st.ctrl_two = req.wdata & gp_pin_pkg::CTRL_TWO_WMSK;
               end
               gp_pin_pkg::OUT_VALUE_REG: begin
                  next_st.out_value = req.wdata & gp_pin_pkg::PIN_MASK;
               end
               gp_pin_pkg::OUT_EN_REG: begin
                  next_st.out_en = req.wdata & gp_pin_pkg::PIN_MASK;
               end
               default: begin
                  // Other addresses are not held here; writes are dropped.
               end
            endcase
         end
      end
      // Reads return zero for anything not mapped here.
      if (req.rd) begin
         if (req.addr == gp_pin_pkg::PAGE_SEL_REG) begin
            next_st.rd_data = st.page;
         end else if (page_ok) begin
            case (req.addr)
               gp_pin_pkg::CTRL_TWO_REG: begin
                  next_st.rd_data = st.ctrl_two;
                  next_st.rd_data[gp_pin_pkg::HOLD_READ_BIT] =
                     synced[gp_pin_pkg::HOLD_SYNC_BIT];
               end
               gp_pin_pkg::IN_LEVEL_REG: begin
                  next_st.rd_data = synced[15:0] & gp_pin_pkg::PIN_MASK;
               end
               gp_pin_pkg::OUT_VALUE_REG: begin
                  next_st.rd_data = st.out_value;
               end
               gp_pin_pkg::OUT_EN_REG: begin
                  next_st.rd_data = st.out_en;
               end
               default: begin
                  next_st.rd_data = '0;
               end
            endcase
         end
      end
      // General-purpose pins follow the output and enable registers; others are input unless a dedicated function below drives them.
      next_st.pads.gpio_out = st.out_value & owned;
      next_st.pads.gpio_oe  = st.out_en & owned;
      // Dedicated two-wire data and clocks, released high when asked.
      if (!owned[gp_pin_pkg::SDA_PIN]) begin
         next_st.pads.gpio_out[gp_pin_pkg::SDA_PIN] = func.sda;
         next_st.pads.gpio_oe[gp_pin_pkg::SDA_PIN]  =
            drive_en(func.sda, st.ctrl_two[gp_pin_pkg::TWI_REL_BIT]);
      end
      if (!owned[gp_pin_pkg::SCL0_PIN]) begin
         next_st.pads.gpio_out[gp_pin_pkg::SCL0_PIN] = func.scl[0];
         next_st.pads.gpio_oe[gp_pin_pkg::SCL0_PIN]  =
            drive_en(func.scl[0], st.ctrl_two[gp_pin_pkg::TWI_REL_BIT]);
      end
      if (!owned[gp_pin_pkg::SCL1_PIN]) begin
         next_st.pads.gpio_out[gp_pin_pkg::SCL1_PIN] = func.scl[1];
         next_st.pads.gpio_oe[gp_pin_pkg::SCL1_PIN]  =
            drive_en(func.scl[1], st.ctrl_two[gp_pin_pkg::TWI_REL_BIT]);
      end
      // Quick link loss flag is a push-pull output only at the dedicated code.
      if (st.ctrl_two[gp_pin_pkg::PIN9_LSB +: 2] == gp_pin_pkg::SEL_DEDICATED) begin
         next_st.pads.gpio_out[gp_pin_pkg::LINK_PIN] = func.link_loss;
         next_st.pads.gpio_oe[gp_pin_pkg::LINK_PIN]  = 1'b1;
      end
      // Low-power hold pin: active-low direction bit, data bit.
      next_st.pads.hold_oe  = !st.ctrl_two[gp_pin_pkg::HOLD_DIR_BIT];
      next_st.pads.hold_out = st.ctrl_two[gp_pin_pkg::HOLD_DATA_BIT];
      // LEDs, with optional release of the high level.
      for (int i = 0; i < 4; i++) begin
         next_st.pads.led_out[i] = func.led[i];
         next_st.pads.led_oe[i]  = drive_en(func.led[i], st.ctrl_two[gp_pin_pkg::LED_REL_BIT]);
      end
      // Pulse-per-second outputs are held off unless enabled.
      next_st.pads.pps_out = func.pulse_per_second_out & {3{st.ctrl_two[gp_pin_pkg::PPS_EN_BIT]}};
      next_st.pads.pps_oe  = {3{st.ctrl_two[gp_pin_pkg::PPS_EN_BIT]}};
   end

   // State registers with their reset values.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st          <= '0;
         st.page     <= gp_pin_pkg::PAGE_MAIN;
         st.ctrl_two <= gp_pin_pkg::CTRL_TWO_RST;
      end else begin
         st <= next_st;
      end
   end

   assign rd_data  = st.rd_data;
   assign rd_valid = st.rd_valid;
   assign pads     = st.pads;

   // A read of the control register on the general page.
   sequence ctrl_read;
      req.rd && page_ok && req.addr == gp_pin_pkg::CTRL_TWO_REG;
   endsequence

   // A read of the input register on the general page.
   sequence input_read;
      req.rd && page_ok && req.addr == gp_pin_pkg::IN_LEVEL_REG;
   endsequence

   chk_pair_select: assert property (@(posedge clk) disable iff (!resetn)
      st.ctrl_two[15:14] != gp_pin_pkg::SEL_GENERAL |=> pads.gpio_oe[13:12] == 2'h0)
      else $error("pins 13 and 12 driven while not selected");
   chk_hold_dir: assert property (@(posedge clk) disable iff (!resetn)
      ##1 pads.hold_oe == !$past(st.ctrl_two[gp_pin_pkg::HOLD_DIR_BIT]))
      else $error("hold pin direction does not follow control bit");
   chk_hold_level: assert property (@(posedge clk) disable iff (!resetn)
      pads.hold_oe |-> pads.hold_out == $past(st.ctrl_two[gp_pin_pkg::HOLD_DATA_BIT]))
      else $error("hold pin level differs from data bit");
   chk_hold_read: assert property (@(posedge clk) disable iff (!resetn)
      ctrl_read |=> rd_valid && rd_data[11] == $past(synced[gp_pin_pkg::HOLD_SYNC_BIT]))
      else $error("hold pin readback wrong");
   chk_twi_release: assert property (@(posedge clk) disable iff (!resetn)
      st.ctrl_two[gp_pin_pkg::TWI_REL_BIT] && func.sda && !owned[gp_pin_pkg::SDA_PIN]
      |=> !pads.gpio_oe[gp_pin_pkg::SDA_PIN])
      else $error("two-wire data high is driven while released");
   // The edge that releases reset still registers reset pads, so attempts start once reset is high.
   chk_led_release: assert property (@(posedge clk) disable iff (!resetn)
      resetn |=> pads.led_oe ==
         ~($past(func.led) & {4{$past(st.ctrl_two[gp_pin_pkg::LED_REL_BIT])}}))
      else $error("LED enable does not match release mode");
   chk_pps_gate: assert property (@(posedge clk) disable iff (!resetn)
      !st.ctrl_two[gp_pin_pkg::PPS_EN_BIT] |=> pads.pps_oe == 3'h0 && pads.pps_out == 3'h0)
      else $error("pulse outputs active while disabled");
   chk_link_dedicated: assert property (@(posedge clk) disable iff (!resetn)
      resetn && st.ctrl_two[gp_pin_pkg::PIN9_LSB +: 2] == gp_pin_pkg::SEL_DEDICATED
      |=> pads.gpio_oe[gp_pin_pkg::LINK_PIN] &&
          pads.gpio_out[gp_pin_pkg::LINK_PIN] == $past(func.link_loss))
      else $error("link loss flag not on its pin");
   chk_input_read: assert property (@(posedge clk) disable iff (!resetn)
      input_read |=> rd_data == ($past(synced[15:0]) & gp_pin_pkg::PIN_MASK))
      else $error("input register does not show pin levels");
   chk_out_drive: assert property (@(posedge clk) disable iff (!resetn)
      owned[13] && st.out_en[13] |=> pads.gpio_oe[13] && pads.gpio_out[13] == $past(st.out_value[13]))
      else $error("general pin does not show output register");
   chk_out_reserved: assert property (@(posedge clk) disable iff (!resetn)
      (st.out_value & ~gp_pin_pkg::PIN_MASK) == 16'h0000)
      else $error("reserved output bits became set");

endmodule

// ==== rtl/pin_level_sync.sv ====
// Three-stage synchroniser for pad levels entering the management clock domain.
// Assumes the pads change asynchronously; a level is taken once stages two and three agree.
module pin_level_sync (
   input  wire logic                           clk,
   input  wire logic                           resetn,
   input  wire logic [gp_pin_pkg::SYNC_W-1:0]  raw,
   output logic      [gp_pin_pkg::SYNC_W-1:0]  level
);

   gp_pin_pkg::sync_state_t st;       // Registered state.
   gp_pin_pkg::sync_state_t next_st;  // Next state.

   // Shift the chain and update the accepted level where the late stages agree.
   always_comb begin
      next_st       = st;
      next_st.s1    = raw;
      next_st.s2    = st.s1;
      next_st.s3    = st.s2;
      next_st.level = (~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.level);
   end

   // Registers; the first stage is only read by the second.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level = st.level;

endmodule

// ==== sim/pad_board.sv ====
// Board model: the pads of the pin block with outside pull-ups and bench drivers.
// Assumes the pad drive of the pin block and levels that the bench puts on the board.
module pad_board (
   input  wire gp_pin_pkg::pad_drive_t pads,
   input  wire logic [15:0]            ext_en,
   input  wire logic [15:0]            ext_val,
   output logic      [15:0]            gpio_in,
   output logic                        hold_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // A pad shows the block's level while it drives, else the outside driver or the pull-up.
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         gpio_in[i] = pads.gpio_oe[i] ? pads.gpio_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
      end
      hold_in = pads.hold_oe ? pads.hold_out : 1'b1;
   end
endmodule

// ==== sim/phy_gpio_pin_control_tb.sv ====
// Self-checking bench of the general-purpose pin block with a board model on its pads.
// Assumes register access by one-cycle strobes and pads settled two edges after a write.
module phy_gpio_pin_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                    clk = 1'b0;
   logic                    resetn = 1'b0;
   gp_pin_pkg::mgmt_req_t   req = '0;
   logic [15:0]             rd_data;
   logic                    rd_valid;
   logic [15:0]             gpio_in;
   logic                    hold_in;
   logic [3:0]              low_pins_general = 4'h0;
   gp_pin_pkg::func_drive_t func = '{sda:1'b1, scl:2'h3, link_loss:1'b1, led:4'h5, pulse_per_second_out:3'h5};
   gp_pin_pkg::pad_drive_t  pads;
   logic [15:0]             ext_en = 16'h0000;
   logic [15:0]             ext_val = 16'h0000;
   int                      error_cnt = 0;
   int                      checks = 0;

   // The clock toggles every half period of 4 ns.
   always #4 clk = ~clk;

   phy_gpio_pin_control phy_gpio_pin_control_inst (.clk(clk), .resetn(resetn), .req(req),
      .rd_data(rd_data), .rd_valid(rd_valid), .gpio_in(gpio_in),
      .low_power_hold_pin_in(hold_in), .low_pins_general(low_pins_general), .func(func),
      .pads(pads));
   pad_board pad_board_inst (.pads(pads), .ext_en(ext_en), .ext_val(ext_val),
      .gpio_in(gpio_in), .hold_in(hold_in));

   // Prints the counts and the verdict, then stops.
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Compares one value and reports a difference at once.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Writes one register with a one-cycle strobe.
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      req <= '{wr:1'b1, rd:1'b0, addr:a, wdata:d};
      @(posedge clk);
      req <= '0;
   endtask

   // Reads one register; the answer stands in the cycle after the read edge.
   task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
      @(posedge clk);
      req <= '{wr:1'b0, rd:1'b1, addr:a, wdata:16'h0000};
      @(posedge clk);
      req <= '0;
      #1;
      chk({15'h0, rd_valid}, 16'h0001);
      chk(rd_data, exp);
   endtask

   // Lets a register write reach the pads.
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask

   // Reset values and the pads that follow from them.
   task automatic t_reset();
      wr(gp_pin_pkg::PAGE_SEL_REG, gp_pin_pkg::PAGE_GENERAL);
      rdchk(gp_pin_pkg::CTRL_TWO_REG, 16'h2e00);
      rdchk(gp_pin_pkg::OUT_VALUE_REG, 16'h0000);
      chk({15'h0, pads.hold_oe}, 16'h0000);
      chk({12'h0, pads.led_oe}, 16'h000a);
      chk({13'h0, pads.pps_oe}, 16'h0000);
      chk({15'h0, pads.gpio_oe[8]}, 16'h0000);
   endtask

   // The hold pin as output, both levels, read back through the synchroniser.
   task automatic t_hold();
      wr(gp_pin_pkg::CTRL_TWO_REG, 16'h1e00);
      settle();
      chk({14'h0, pads.hold_oe, pads.hold_out}, 16'h0003);
      repeat (5) @(posedge clk);
      rdchk(gp_pin_pkg::CTRL_TWO_REG, 16'h1e00);
      wr(gp_pin_pkg::CTRL_TWO_REG, 16'h0e00);
      settle();
      chk({14'h0, pads.hold_oe, pads.hold_out}, 16'h0002);
      repeat (5) @(posedge clk);
      rdchk(gp_pin_pkg::CTRL_TWO_REG, 16'h0600);
   endtask

   // Release modes of the two-wire outputs, LED drive with release off, and the pulse gate.
   task automatic t_release();
      wr(gp_pin_pkg::CTRL_TWO_REG, 16'h2000);
      settle();
      chk({8'h0, pads.led_oe, pads.led_out}, 16'h00f5);
      chk({14'h0, pads.gpio_oe[8], pads.gpio_out[8]}, 16'h0003);
      wr(gp_pin_pkg::CTRL_TWO_REG, 16'h2700);
      settle();
      chk({10'h0, pads.pps_oe, pads.pps_out}, 16'h003d);
      chk({15'h0, pads.gpio_oe[8]}, 16'h0000);
      // A low level is always driven, even in release mode.
      @(posedge clk);
      func.sda <= 1'b0;
      func.link_loss <= 1'b0;
      settle();
      chk({14'h0, pads.gpio_oe[8], pads.gpio_out[8]}, 16'h0002);
      chk({14'h0, pads.gpio_oe[9], pads.gpio_out[9]}, 16'h0002);
      @(posedge clk);
      func.sda <= 1'b1;
      func.link_loss <= 1'b1;
      wr(gp_pin_pkg::CTRL_TWO_REG, 16'h2600);
   endtask

   // Pin levels from outside drivers; reserved bits read zero.
   task automatic t_input();
      ext_en <= 16'hffff;
      ext_val <= 16'hdaed;
      repeat (6) @(posedge clk);
      rdchk(gp_pin_pkg::IN_LEVEL_REG, 16'h1a21);
      @(posedge clk);
      ext_en <= 16'h0000;
   endtask

   // Output register, enables and every select code of the select fields.
   task automatic t_output();
      logic [1:0] c;
      @(posedge clk);
      low_pins_general <= 4'hf;
      wr(gp_pin_pkg::OUT_EN_REG, 16'hffff);
      wr(gp_pin_pkg::OUT_VALUE_REG, 16'hffff);
      rdchk(gp_pin_pkg::OUT_VALUE_REG, 16'h3f33);
      wr(gp_pin_pkg::OUT_VALUE_REG, 16'h2821);
      for (int k = 0; k < 4; k++) begin
         c = 2'(k);
         wr(gp_pin_pkg::CTRL_TWO_REG, {c, 6'h26, c, c, c, c});
         settle();
         chk(pads.gpio_oe & 16'h3c00, (c == 2'h3) ? 16'h3c00 : 16'h0000);
         chk({15'h0, pads.gpio_oe[9]}, {15'h0, c == 2'h0 || c == 2'h3});
         if (c == 2'h0) begin
            chk({15'h0, pads.gpio_out[9]}, 16'h0001);
         end
         if (c == 2'h3) begin
            chk(pads.gpio_oe & gp_pin_pkg::PIN_MASK, 16'h3f33);
            chk(pads.gpio_out & gp_pin_pkg::PIN_MASK, 16'h2821);
         end
      end
      // Cleared enable bits must turn owned pins back into inputs.
      wr(gp_pin_pkg::OUT_EN_REG, 16'h0f0f);
      rdchk(gp_pin_pkg::OUT_EN_REG, 16'h0f03);
      settle();
      chk(pads.gpio_oe & gp_pin_pkg::PIN_MASK, 16'h0f03);
   endtask

   // Writes outside the general page are dropped and reads there give zero.
   task automatic t_page();
      wr(gp_pin_pkg::PAGE_SEL_REG, gp_pin_pkg::PAGE_MAIN);
      wr(gp_pin_pkg::OUT_VALUE_REG, 16'h0000);
      rdchk(gp_pin_pkg::CTRL_TWO_REG, 16'h0000);
      wr(gp_pin_pkg::PAGE_SEL_REG, gp_pin_pkg::PAGE_GENERAL);
      rdchk(gp_pin_pkg::OUT_VALUE_REG, 16'h2821);
   endtask

   // Main sequence: reset for two cycles, then every scenario in turn.
   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (5) @(posedge clk);
      t_reset();
      t_hold();
      t_release();
      t_input();
      t_output();
      t_page();
      tally_and_finish();
   end

   // Cuts a hang short and counts it as a mismatch.
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      tally_and_finish();
   end
endmodule
